// [logic/wmm_exec.sv]
/*
 execution datapath for the word pair move, byte multiply and idle instruction.
 assumes the decoder fetches operands, holds req stable while start is pulsed,
 and the register file applies the result strobes when done rises.
*/
`timescale 1ns/1ps
module wmm_exec (
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // request from the decoder
   input wire logic start,
   input wire wmm_pkg::wmm_req_type req,
   // answer to the decoder and register file
   output logic busy,
   output logic done,
   output wmm_pkg::wmm_result_type result,
   // memory access request, never raised here
   output logic mem_read
);
   typedef enum logic [1:0] {WMM_IDLE, WMM_RUN, WMM_WAIT_MUL} wmm_state_type;

   wmm_state_type state, next_state;
   logic [5:0] count, next_count;
   wmm_pkg::wmm_req_type held, next_held;
   logic next_busy, next_done;
   wmm_pkg::wmm_result_type next_result;
   logic mul_start;
   logic mul_busy;
   logic [15:0] mul_product;
   logic [15:0] move_word;
   logic [7:0] move_high;
   logic [7:0] flags_new;
   logic next_mem_read;
   logic is_move, is_multiply, is_idle;
   logic [7:0] add_base_high, add_base_low;
   logic [7:0] add_term_high, add_term_low;
   logic [8:0] low_sum;
   logic [7:0] high_sum;
   wmm_pkg::wmm_result_type done_result;

   wmm_multiplier i_wmm_multiplier (
      .clk(clk),
      .rst_b(rst_b),
      .start(mul_start),
      .multiplicand(held.mul_source),
      .multiplier(held.mul_operand),
      .product(mul_product),
      .busy(mul_busy)
   );

   // operation class of the held request
   always_comb begin
      is_multiply = (held.op == wmm_pkg::WMM_OP_MULTIPLY);
      is_idle = (held.op == wmm_pkg::WMM_OP_IDLE);
      is_move = !is_multiply && !is_idle;
   end

   // shared adder, low byte first so the carry into the high byte is explicit
   always_comb begin
      // offset form: pair plus sign-extended byte
      add_base_high = held.source_pair[15:8];
      add_base_low = held.source_pair[7:0];
      add_term_high = {8{held.signed_byte_offset[7]}};
      add_term_low = held.signed_byte_offset;
      if (held.op == wmm_pkg::WMM_OP_MOVE_INDEX) begin
         // indexed form: word immediate plus B, only the address is kept
         add_base_high = held.word_immediate[15:8];
         add_base_low = held.word_immediate[7:0];
         add_term_high = 8'h00;
         add_term_low = held.reg_b;
      end
      low_sum = {1'b0, add_base_low} + {1'b0, add_term_low};
      high_sum = add_base_high + add_term_high + {7'h00, low_sum[8]};
   end

   // word value to move
   always_comb begin
      case (held.op)
         wmm_pkg::WMM_OP_MOVE_IMM: move_word = held.word_immediate;
         wmm_pkg::WMM_OP_MOVE_PAIR: move_word = held.source_pair;
         wmm_pkg::WMM_OP_MOVE_INDEX: move_word = {high_sum, low_sum[7:0]};
         wmm_pkg::WMM_OP_MOVE_OFFSET: move_word = {high_sum, low_sum[7:0]};
         default: move_word = wmm_pkg::RESET_WORD;
      endcase
   end

   always_comb begin
      move_high = is_multiply ? mul_product[15:8] : move_word[15:8];
      flags_new = wmm_pkg::RESET_BYTE;
      flags_new[wmm_pkg::FLAG_C] = 1'b0;
      flags_new[wmm_pkg::FLAG_V] = 1'b0;
      flags_new[wmm_pkg::FLAG_N] = move_high[7];
      flags_new[wmm_pkg::FLAG_Z] = (move_high == 8'h00);
   end

   // result presented with done
   always_comb begin
      done_result = '0;
      done_result.pc_step = 1'b1;
      if (is_multiply) begin
         done_result.ab_write = 1'b1;
         done_result.reg_a = mul_product[15:8];
         done_result.reg_b = mul_product[7:0];
      end else if (is_move) begin
         done_result.pair_write = 1'b1;
         done_result.low_addr = held.dest_low;
         // a zero dest_low wraps to FF; keeping it above zero is software's duty
         done_result.high_addr = held.dest_low - 8'h01;
         done_result.word = move_word;
      end
      if (!is_idle) begin
         done_result.flags_write = 1'b1;
         done_result.flags_mask = 8'hF0;
         done_result.flags = flags_new;
      end
   end

   // cycle count per instruction
   function automatic logic [5:0] cycles_of(input wmm_pkg::wmm_op_type op);
      case (op)
         wmm_pkg::WMM_OP_MOVE_IMM: cycles_of = wmm_pkg::CYC_MOVE_IMM;
         wmm_pkg::WMM_OP_MOVE_PAIR: cycles_of = wmm_pkg::CYC_MOVE_PAIR;
         wmm_pkg::WMM_OP_MOVE_INDEX: cycles_of = wmm_pkg::CYC_MOVE_INDEX;
         wmm_pkg::WMM_OP_MOVE_OFFSET: cycles_of = wmm_pkg::CYC_MOVE_OFFSET;
         wmm_pkg::WMM_OP_MULTIPLY: cycles_of = wmm_pkg::CYC_MULTIPLY;
         default: cycles_of = wmm_pkg::CYC_IDLE;
      endcase
   endfunction

   // memory read request: the indexed form only forms an address
   always_comb begin
      next_mem_read = 1'b0;
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         mem_read <= 1'b0;
      end else begin
         mem_read <= next_mem_read;
      end
   end

   always_comb begin
      next_state = state;
      next_count = count;
      next_held = held;
      next_busy = busy;
      next_done = 1'b0;
      next_result = '0;
      mul_start = 1'b0;
      case (state)
         WMM_IDLE: begin
            if (start) begin
               next_held = req;
               // count includes the result cycle
               next_count = cycles_of(req.op) - 6'h1;
               next_busy = 1'b1;
               next_state = WMM_RUN;
            end
         end
         WMM_RUN: begin
            if (count == cycles_of(held.op) - 6'h1 && is_multiply) begin
               mul_start = 1'b1;
            end
            if (count > 6'h1) begin
               next_count = count - 6'h1;
            end else begin
               next_state = mul_busy ? WMM_WAIT_MUL : WMM_IDLE;
            end
            if (count <= 6'h1 && !mul_busy) begin
               next_done = 1'b1;
               next_busy = 1'b0;
               next_result = done_result;
            end
         end
         default: begin
            // multiplier still running when the count ran out
            if (!mul_busy) begin
               next_done = 1'b1;
               next_busy = 1'b0;
               next_state = WMM_IDLE;
               next_result = done_result;
            end
         end
      endcase
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         state <= WMM_IDLE;
         count <= wmm_pkg::RESET_COUNT;
         held <= '0;
         busy <= 1'b0;
         done <= 1'b0;
         result <= '0;
      end else begin
         state <= next_state;
         count <= next_count;
         held <= next_held;
         busy <= next_busy;
         done <= next_done;
         result <= next_result;
      end
   end
endmodule // wmm_exec

// [logic/wmm_multiplier.sv]
/*
 unsigned 8x8 shift-add multiplier, one partial product per cycle.
 assumes start is pulsed only while busy is low.
*/
`timescale 1ns/1ps
module wmm_multiplier (
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // request
   input wire logic start,
   input wire logic [7:0] multiplicand,
   input wire logic [7:0] multiplier,
   // answer
   output logic [15:0] product,
   output logic busy
);
   logic [15:0] acc, next_acc;
   logic [15:0] mcand, next_mcand;
   logic [7:0] mplier, next_mplier;
   logic [3:0] steps, next_steps;

   always_comb begin
      next_acc = acc;
      next_mcand = mcand;
      next_mplier = mplier;
      next_steps = steps;
      if (start) begin
         next_acc = wmm_pkg::RESET_WORD;
         next_mcand = {8'h00, multiplicand};
         next_mplier = multiplier;
         next_steps = 4'h8;
      end else if (steps != 4'h0) begin
         if (mplier[0]) begin
            next_acc = acc + mcand;
         end
         next_mcand = {mcand[14:0], 1'b0};
         next_mplier = {1'b0, mplier[7:1]};
         next_steps = steps - 4'h1;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         acc <= 16'h0000;
         mcand <= 16'h0000;
         mplier <= 8'h00;
         steps <= 4'h0;
      end else begin
         acc <= next_acc;
         mcand <= next_mcand;
         mplier <= next_mplier;
         steps <= next_steps;
      end
   end

   assign product = acc;
   assign busy = (steps != 4'h0);
endmodule // wmm_multiplier

// [logic/wmm_pkg.sv]
/*
 package for the word move / multiply / idle execution datapath:
 opcodes, cycle counts, operation kinds and the request and result structs.
 assumes the decoder presents operands already fetched from the register file.
*/
package wmm_pkg;

   // operation codes
   localparam logic [7:0] OP_MOVE_IMM = 8'h88;
   localparam logic [7:0] OP_MOVE_PAIR = 8'h98;
   localparam logic [7:0] OP_MOVE_INDEX = 8'hA8;
   localparam logic [7:0] OP_PREFIX = 8'hF4;
   localparam logic [7:0] OP_MOVE_OFFSET = 8'hE8;
   localparam logic [7:0] OP_IDLE = 8'hFF;

   // cycle counts per instruction
   localparam logic [5:0] CYC_MOVE_IMM = 6'h0D;
   localparam logic [5:0] CYC_MOVE_PAIR = 6'h0C;
   localparam logic [5:0] CYC_MOVE_INDEX = 6'h0F;
   localparam logic [5:0] CYC_MOVE_OFFSET = 6'h14;
   localparam logic [5:0] CYC_IDLE = 6'h07;
   localparam logic [5:0] CYC_MULTIPLY = 6'h2D;

   // status flag positions in the status byte
   localparam int FLAG_C = 7;
   localparam int FLAG_N = 6;
   localparam int FLAG_Z = 5;
   localparam int FLAG_V = 4;

   localparam logic [7:0] RESET_BYTE = 8'h00;
   localparam logic [15:0] RESET_WORD = 16'h0000;
   localparam logic [5:0] RESET_COUNT = 6'h00;

   typedef enum logic [2:0] {
      WMM_OP_MOVE_IMM,
      WMM_OP_MOVE_PAIR,
      WMM_OP_MOVE_INDEX,
      WMM_OP_MOVE_OFFSET,
      WMM_OP_MULTIPLY,
      WMM_OP_IDLE
   } wmm_op_type;

   typedef struct packed {
      wmm_op_type op;
      logic [7:0] dest_low;
      logic [15:0] word_immediate;
      logic [15:0] source_pair;
      logic [7:0] signed_byte_offset;
      logic [7:0] reg_b;
      logic [7:0] mul_source;
      logic [7:0] mul_operand;
   } wmm_req_type;

   typedef struct packed {
      logic pair_write;
      logic [7:0] high_addr;
      logic [7:0] low_addr;
      logic [15:0] word;
      logic ab_write;
      logic [7:0] reg_a;
      logic [7:0] reg_b;
      logic flags_write;
      logic [7:0] flags_mask;
      logic [7:0] flags;
      logic pc_step;
   } wmm_result_type;

endpackage

// [sim/test_word_move_multiply_exec.sv]
/* self-checking bench for the execution datapath.
   assumes the partner model waits for done per request. */
`timescale 1ns/1ps
module test_word_move_multiply_exec;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic start, busy, done, mem_read;
   wmm_pkg::wmm_req_type req;
   wmm_pkg::wmm_result_type result;
   wmm_pkg::wmm_result_type exp_q[$];
   logic [5:0] n_q[$];
   logic [5:0] cyc_tab[6] = '{wmm_pkg::CYC_MOVE_IMM, wmm_pkg::CYC_MOVE_PAIR,
      wmm_pkg::CYC_MOVE_INDEX, wmm_pkg::CYC_MOVE_OFFSET, wmm_pkg::CYC_MULTIPLY, wmm_pkg::CYC_IDLE};
   int mismatches = 0;
   int comparisons = 0;
   int cnt = 0;
   always #2 clk = ~clk;
   wmm_exec i_wmm_exec (.clk(clk), .rst_b(rst_b), .start(start), .req(req), .busy(busy),
      .done(done), .result(result), .mem_read(mem_read));
   wmm_decoder_model i_wmm_decoder_model (.clk(clk), .start(start), .req(req), .busy(busy),
      .done(done));
   task automatic fail(input string s);
      mismatches++;
      $display("[FAIL] %0t %s", $time, s);
   endtask
   task automatic check_result(input wmm_pkg::wmm_result_type g, input wmm_pkg::wmm_result_type e);
      comparisons++;
      if (!e.ab_write) {g.reg_a, g.reg_b} = {e.reg_a, e.reg_b};
      if (!e.pair_write) {g.high_addr, g.low_addr, g.word} = {e.high_addr, e.low_addr, e.word};
      if (!e.flags_write) {g.flags_mask, g.flags} = {e.flags_mask, e.flags};
      g.flags[3:0] = e.flags[3:0];
      if (g !== e) fail("result");
   endtask
   task automatic check_cycles(input logic [5:0] g, input logic [5:0] e);
      comparisons++;
      if (g !== e) fail("cycle count");
   endtask
   task automatic check_quiet(input logic b, input logic m);
      comparisons++;
      if ({b, m} !== 2'b00) fail("busy or memory read");
   endtask
   function automatic wmm_pkg::wmm_result_type expect_of(input wmm_pkg::wmm_req_type r);
      wmm_pkg::wmm_result_type e;
      logic [15:0] p;
      e = '0;
      p = r.mul_source * r.mul_operand;
      case (r.op)
         wmm_pkg::WMM_OP_MOVE_IMM: e.word = r.word_immediate;
         wmm_pkg::WMM_OP_MOVE_PAIR: e.word = r.source_pair;
         wmm_pkg::WMM_OP_MOVE_INDEX: e.word = r.word_immediate + {8'h00, r.reg_b};
         wmm_pkg::WMM_OP_MOVE_OFFSET: e.word = r.source_pair +
            {{8{r.signed_byte_offset[7]}}, r.signed_byte_offset};
         wmm_pkg::WMM_OP_MULTIPLY: {e.ab_write, e.reg_a, e.reg_b} = {1'b1, p};
         default: ;
      endcase
      e.pc_step = 1'b1;
      e.pair_write = r.op < wmm_pkg::WMM_OP_MULTIPLY;
      e.high_addr = r.dest_low - 8'h01;
      e.low_addr = r.dest_low;
      e.flags_write = r.op != wmm_pkg::WMM_OP_IDLE;
      e.flags_mask = 8'hF0;
      p = e.pair_write ? e.word : p;
      e.flags[7:4] = {1'b0, p[15], p[15:8] == 8'h00, 1'b0};
      return e;
   endfunction
   always @(posedge clk) begin
      if (done === 1'b1) begin
         check_result(result, exp_q.pop_front());
         check_cycles(6'(cnt + 1), n_q.pop_front());
         check_quiet(busy, mem_read);
      end
      cnt = (start && !busy) ? 0 : cnt + 1;
   end
   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   initial begin
      #20000;
      fail("timeout");
      tally_and_finish();
   end
   initial begin
      wmm_pkg::wmm_req_type r;
      logic [95:0] bits;
      void'($urandom(56475));
      repeat (6) @(posedge clk);
      check_quiet(busy || done, mem_read);
      #1 rst_b = 1'b1;
      for (int i = 0; i < 30; i++) begin
         bits = {$urandom, $urandom, $urandom};
         r = bits[$bits(r)-1:0];
         r.op = wmm_pkg::wmm_op_type'(i % 6);
         if (r.dest_low == 8'h00 || i < 6) r.dest_low = 8'h01;
         if (i < 6) begin
            {r.word_immediate, r.reg_b, r.mul_source, r.mul_operand} = 40'hFFFF_FFFF_FF;
            {r.source_pair, r.signed_byte_offset} = 24'h0050_80;
         end
         exp_q.push_back(expect_of(r));
         n_q.push_back(cyc_tab[i % 6]);
         i_wmm_decoder_model.issue(r, i >= 12 && i < 18);
      end
      repeat (3) @(posedge clk);
      if (exp_q.size() != 0) fail("result missing");
      tally_and_finish();
   end
endmodule // test_word_move_multiply_exec

// [sim/wmm_decoder_model.sv]
/* decoder and register file stand-in issuing requests.
   assumes requests change just after the rising edge. */
`timescale 1ns/1ps
module wmm_decoder_model (
   // clock
   input wire logic clk,
   // handshake
   output logic start,
   output wmm_pkg::wmm_req_type req,
   input wire logic busy,
   input wire logic done
);
   initial begin
      start = 1'b0;
      req = '0;
   end
   // poke retries start while busy
   task automatic issue(input wmm_pkg::wmm_req_type r, input bit poke);
      int n;
      n = 0;
      req = r;
      start = 1'b1;
      @(posedge clk);
      #1 start = 1'b0;
      req = ~r;
      if (poke) begin
         @(posedge clk);
         #1 start = 1'b1;
         @(posedge clk);
         #1 start = 1'b0;
      end
      do @(posedge clk); while (done !== 1'b1 && ++n < 100);
      #1;
   endtask
endmodule // wmm_decoder_model

// [sim/wmm_exec_props.sv]
/* port checks for the execution datapath.
   assumes one clock, async active-low reset. */
`timescale 1ns/1ps
module wmm_exec_props (
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // request
   input wire logic start,
   input wire wmm_pkg::wmm_req_type req,
   // answer
   input wire logic busy,
   input wire logic done,
   input wire wmm_pkg::wmm_result_type result,
   input wire logic mem_read
);
   wmm_pkg::wmm_req_type held;
   wmm_pkg::wmm_req_type next_held;
   logic take;
   assign take = start && !busy;
   // request as accepted
   always_comb begin
      next_held = take ? req : held;
   end
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         held <= '0;
      end else begin
         held <= next_held;
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   a_no_mem_read: assert property (!mem_read) else $error("memory read");
   a_idle_time: assert property (take && req.op == wmm_pkg::WMM_OP_IDLE |->
      ##1 (busy && !done) [*6] ##1 done) else $error("idle timing");
   a_index_time: assert property (take && req.op == wmm_pkg::WMM_OP_MOVE_INDEX |->
      ##1 (busy && !done) [*8] ##7 done) else $error("index timing");
   a_offset_time: assert property (take && req.op == wmm_pkg::WMM_OP_MOVE_OFFSET |->
      ##20 done) else $error("offset timing");
   a_mult_time: assert property (take && req.op == wmm_pkg::WMM_OP_MULTIPLY |->
      ##45 done) else $error("multiply timing");
   a_pair_addr: assert property (done && held.op < wmm_pkg::WMM_OP_MULTIPLY |->
      result.pair_write && result.low_addr == held.dest_low &&
      result.high_addr == held.dest_low - 8'h01) else $error("pair address");
   a_index_sum: assert property (done && held.op == wmm_pkg::WMM_OP_MOVE_INDEX |->
      result.word == held.word_immediate + {8'h00, held.reg_b}) else $error("index sum");
   a_product_ab: assert property (done && held.op == wmm_pkg::WMM_OP_MULTIPLY |->
      result.ab_write && {result.reg_a, result.reg_b} == held.mul_source * held.mul_operand)
      else $error("product");
   a_move_flags: assert property (done && result.pair_write |-> result.flags[7:4] ==
      {1'b0, result.word[15], result.word[15:8] == 8'h00, 1'b0}) else $error("move flags");
   a_idle_quiet: assert property (done && held.op == wmm_pkg::WMM_OP_IDLE |->
      result.pc_step && !result.pair_write && !result.ab_write && !result.flags_write)
      else $error("idle wrote");
   a_offset_sum: assert property (done && held.op == wmm_pkg::WMM_OP_MOVE_OFFSET |->
      result.word == held.source_pair + {{8{held.signed_byte_offset[7]}},
      held.signed_byte_offset}) else $error("offset sum");
   a_mult_flags: assert property (done && result.ab_write |-> result.flags[7:4] ==
      {1'b0, result.reg_a[7], result.reg_a == 8'h00, 1'b0}) else $error("multiply flags");
   c_mult: cover property (done && result.ab_write);
   c_index: cover property (done && held.op == wmm_pkg::WMM_OP_MOVE_INDEX);
   c_refused: cover property (start && busy);
endmodule // wmm_exec_props
bind wmm_exec wmm_exec_props i_wmm_exec_props (.clk(clk), .rst_b(rst_b), .start(start),
   .req(req), .busy(busy), .done(done), .result(result), .mem_read(mem_read));
